// file: rtl/bcs_pkg.sv
// Package: register map, field positions, reset values, timing counts.
// Assumes a 100 MHz sys_clk.
package bcs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_PROFILE_MSB = 4'h7;
  localparam logic [3:0] OFF_COMMAND = 4'h8;
  localparam logic [3:0] OFF_VOLTAGE = 4'h9;
  localparam logic [3:0] OFF_BATT_CHG = 4'hA;
  localparam logic [3:0] OFF_WARNING = 4'hB;
  localparam logic [3:0] OFF_STORAGE = 4'hC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_LOWBAT = 7;
  localparam int BIT_EW = 6;
  localparam int BIT_ALARM = 5;
  localparam int BIT_READY = 0;
  localparam int BIT_ONDEMAND = 0;
  localparam int BIT_CONT = 1;
  localparam int BIT_FORCE = 2;
  localparam int BIT_OPTRST = 3;
  localparam int BIT_AUTO = 7;
  localparam int BIT_EW_EN = 4;
  localparam int BIT_CAPMAX = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_VSET = 4'h9;
  localparam logic [3:0] RST_VFIX = 4'h0;
  localparam logic [2:0] RST_VMIN = 3'h0;
  localparam logic [2:0] RST_ICH = 3'h2;
  localparam logic [5:0] RST_PROF = 6'h01;
  localparam logic [2:0] ICH_MAX_LEGAL = 3'h4;
  localparam logic [5:0] PROF_FIXED = 6'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int WARN_PULSE_NS = 1000;
  localparam int WARN_PULSE_CYC =
    (WARN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_STANDBY = 4'h1,
    ST_CHARGE = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_IDLE = 4'h8
  } bcs_state_t;

  typedef struct packed {
    logic battery_low;
    logic storage_low;
    logic output_low;
    logic charge_start;
  } bcs_analog_t;

  typedef struct packed {
    logic [3:0] vset;
    logic [3:0] vfix;
    logic [2:0] vmin;
    logic [2:0] ich;
    logic [3:0] vew;
    logic ew_en;
    logic capmax_hi;
    logic auto_mode;
    logic ondemand;
    logic continuous;
    logic force_active;
    logic use_fixed;
  } bcs_config_t;

endpackage

// file: rtl/bcs_pulse_gen.sv
// Pulse generator: holds busy high for a fixed number of cycles.
// Assumes trig is a one-cycle request on sys_clk.
`timescale 1ns/1ps
module bcs_pulse_gen #(
  parameter int CYCLES = 100
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic trig,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_ff;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      cnt_ff <= '0;
    else if (trig)
      cnt_ff <= CW'(CYCLES);
    else if (cnt_ff != '0)
      cnt_ff <= cnt_ff - CW'(1);
  end

  assign busy = (cnt_ff != '0);
endmodule

// file: rtl/bcs_regs.sv
// Control and status register bank of the energy booster.
// Assumes a synchronous byte-wide register port driven by the serial
// interface front end, and analog comparators synchronous to sys_clk.
//
// Behaviour
// - In Charge, battery below threshold sets low-battery status bit 7.
// - Low-battery flag stays set until power cycle; no access clears it.
// - In Active, storage below warning threshold sets status bit 6.
// - Early warning pulses ready pin low for the warning pulse width.
// - In Active, output below set voltage sets bit 5, ready driven low.
// - Early-warning and alarm flags clear when the next charge begins.
// - Status bit 0 reads ready indication, one when asserted.
// - Writing one to command bit 3 discards current profile optimizer result.
// - Auto-mode bit defaults one for two-wire, zero for SPI; SPI ignores ones.
// - Register 9 bits 3:0 select output 1.8 to 3.6 V; default 1001.
// - Register 9 bits 7:4 select storage target 3.4 to 11.0 V.
// - Fixed target applies only when profile index is zero.
// - Register 12 bit 4 selects max storage 9.9 V or 11.0 V.
// - Register 10 bits 2:0 select battery threshold 2.4 to 3.2 V.
// - Register 10 bits 7:5 charge current; default 010; 101-111 forbidden.
// - Active phase end returns to Charge in either operating mode.
// - Early warning raised only while enable bit 4 of register 11 set.
`timescale 1ns/1ps
module bcs_regs
  import bcs_pkg::*;
#(
  parameter bit SPI_VARIANT = 1'b0,
  parameter int PULSE_CYC = WARN_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire bcs_pkg::bcs_analog_t analog_in,
  input wire logic active_done,
  input wire logic ready_level,
  output logic ready_pin,
  output logic opt_reset,
  output bcs_pkg::bcs_config_t cfg,
  output bcs_pkg::bcs_state_t state
);
  import bcs_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic low_battery_ff;
  logic early_warning_flag_ff;
  logic alarm_ff;
  logic [1:0] prof_hi_ff;
  logic [7:0] command_ff;
  logic [7:0] voltage_ff;
  logic [7:0] batt_chg_ff;
  logic [7:0] warning_ff;
  logic storage_ff;
  logic [7:0] rdata_ff;
  logic ready_pin_ff;
  logic opt_reset_ff;
  bcs_config_t cfg_ff;
  bcs_state_t state_ff;
  bcs_state_t nxt_state;
  logic warn_busy;
  logic ew_event;
  logic [5:0] profile;

  function automatic logic wr_hit(input logic [3:0] off);
    wr_hit = reg_wr && (reg_addr == off);
  endfunction

  assign profile = {prof_hi_ff, command_ff[7:4]};
  assign ew_event = (state_ff == ST_ACTIVE) && warning_ff[BIT_EW_EN]
                    && analog_in.storage_low;

  // ----------------------------------------------------------------
  // Operating state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_STANDBY:
        if (command_ff[BIT_ONDEMAND] || command_ff[BIT_CONT])
          nxt_state = ST_CHARGE;
      ST_CHARGE:
        if (command_ff[BIT_FORCE])
          nxt_state = ST_ACTIVE;
        else if (ready_level)
          nxt_state = ST_ACTIVE;
      ST_ACTIVE:
        if (active_done && !command_ff[BIT_FORCE])
          nxt_state = ST_CHARGE;
      default:
        nxt_state = ST_STANDBY;
    endcase
    if (!command_ff[BIT_ONDEMAND] && !command_ff[BIT_CONT]
        && !command_ff[BIT_FORCE])
      nxt_state = ST_STANDBY;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      state_ff <= ST_STANDBY;
    else
      state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      low_battery_ff <= 1'b0;
    else if ((state_ff == ST_CHARGE) && analog_in.battery_low)
      low_battery_ff <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      early_warning_flag_ff <= 1'b0;
    else if (ew_event)
      early_warning_flag_ff <= 1'b1;
    else if (analog_in.charge_start)
      early_warning_flag_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      alarm_ff <= 1'b0;
    else if ((state_ff == ST_ACTIVE) && analog_in.output_low)
      alarm_ff <= 1'b1;
    else if (analog_in.charge_start)
      alarm_ff <= 1'b0;
  end

  bcs_pulse_gen #(
    .CYCLES(PULSE_CYC)
  ) u_pulse (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .trig(ew_event && !early_warning_flag_ff),
    .busy(warn_busy)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      ready_pin_ff <= 1'b0;
    else
      ready_pin_ff <= ready_level && !warn_busy && !alarm_ff;
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      prof_hi_ff <= RST_PROF[5:4];
      command_ff <= {RST_PROF[3:0], 4'h0};
      voltage_ff <= {RST_VFIX, RST_VSET};
      batt_chg_ff <= {RST_ICH, 2'b00, RST_VMIN};
      warning_ff <= {!SPI_VARIANT, 7'h00};
      storage_ff <= 1'b0;
    end
    else
    begin
      if (wr_hit(OFF_PROFILE_MSB))
        prof_hi_ff <= reg_wdata[1:0];
      if (wr_hit(OFF_COMMAND))
        command_ff <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
      if (wr_hit(OFF_VOLTAGE))
        voltage_ff <= reg_wdata;
      if (wr_hit(OFF_BATT_CHG))
        batt_chg_ff <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
      if (wr_hit(OFF_WARNING))
        warning_ff <= {reg_wdata[BIT_AUTO] && !SPI_VARIANT, 2'b00,
                       reg_wdata[4:0]};
      if (wr_hit(OFF_STORAGE))
        storage_ff <= reg_wdata[BIT_CAPMAX];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      opt_reset_ff <= 1'b0;
    else
      opt_reset_ff <= wr_hit(OFF_COMMAND) && reg_wdata[BIT_OPTRST];
  end

  // ----------------------------------------------------------------
  // Configuration out
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      cfg_ff <= '0;
    else
    begin
      cfg_ff.vset <= voltage_ff[3:0];
      cfg_ff.vfix <= voltage_ff[7:4];
      cfg_ff.vmin <= batt_chg_ff[2:0];
      cfg_ff.ich <= (batt_chg_ff[7:5] > ICH_MAX_LEGAL) ? ICH_MAX_LEGAL
                    : batt_chg_ff[7:5];
      cfg_ff.vew <= warning_ff[3:0];
      cfg_ff.ew_en <= warning_ff[BIT_EW_EN];
      cfg_ff.capmax_hi <= storage_ff;
      cfg_ff.auto_mode <= warning_ff[BIT_AUTO];
      cfg_ff.ondemand <= command_ff[BIT_ONDEMAND];
      cfg_ff.continuous <= command_ff[BIT_CONT];
      cfg_ff.force_active <= command_ff[BIT_FORCE];
      cfg_ff.use_fixed <= (profile == PROF_FIXED);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      rdata_ff <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == OFF_STATUS)
        rdata_ff <= {low_battery_ff, early_warning_flag_ff, alarm_ff,
                     4'h0, ready_pin_ff};
      else if (reg_addr == OFF_PROFILE_MSB)
        rdata_ff <= {6'h00, prof_hi_ff};
      else if (reg_addr == OFF_COMMAND)
        rdata_ff <= command_ff;
      else if (reg_addr == OFF_VOLTAGE)
        rdata_ff <= voltage_ff;
      else if (reg_addr == OFF_BATT_CHG)
        rdata_ff <= batt_chg_ff;
      else if (reg_addr == OFF_WARNING)
        rdata_ff <= warning_ff;
      else if (reg_addr == OFF_STORAGE)
        rdata_ff <= {3'h0, storage_ff, 4'h0};
      else
        rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;
  assign ready_pin = ready_pin_ff;
  assign opt_reset = opt_reset_ff;
  assign cfg = cfg_ff;
  assign state = state_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  lowbat_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    low_battery_ff |=> low_battery_ff)
    else $error("low battery flag cleared");
  lowbat_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_ff == ST_CHARGE && analog_in.battery_low) |=> low_battery_ff)
    else $error("low battery not set");
  ew_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ew_event |=> early_warning_flag_ff)
    else $error("early warning not set");
  ew_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!warning_ff[BIT_EW_EN] && !early_warning_flag_ff)
      |=> !early_warning_flag_ff)
    else $error("early warning without enable");
  sequence ew_rise_s;
    ew_event && !early_warning_flag_ff;
  endsequence
  ew_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ew_rise_s |=> ##1 !ready_pin_ff [*2])
    else $error("ready pin not pulsed low");
  alarm_rdy_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    alarm_ff |=> !ready_pin_ff)
    else $error("ready high during alarm");
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (analog_in.charge_start && !ew_event && !analog_in.output_low)
      |=> !early_warning_flag_ff && !alarm_ff)
    else $error("flags not cleared at charge");
  auto_spi_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    SPI_VARIANT |-> !warning_ff[BIT_AUTO])
    else $error("auto mode set on SPI part");
  optrst_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (reg_wr && (reg_addr == OFF_COMMAND) && reg_wdata[BIT_OPTRST])
      |=> opt_reset_ff)
    else $error("optimizer reset missing");
  active_ret_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_ff == ST_ACTIVE && active_done && !command_ff[BIT_FORCE]
     && (command_ff[BIT_ONDEMAND] || command_ff[BIT_CONT]))
      |=> state_ff == ST_CHARGE)
    else $error("active did not return to charge");
endmodule

// file: tb/bcs_host.sv
// Host model: byte writes and reads on the register port.
// Assumes requests are made from one bench process at a time.
`timescale 1ns/1ps
module bcs_host (
  input wire logic sys_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    if (a == 4'hA && d[7:5] > 3'h4)
      d[7:5] = 3'h4;
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge sys_clk);
    #1;
    q = reg_rdata;
  endtask
endmodule

// file: tb/booster_control_status_regs_tb_top.sv
// Testbench: register table, status flags, modes, optimizer reset.
// Assumes bcs_regs driven by the host model on its register port.
`timescale 1ns/1ps
module booster_control_status_regs_tb_top;
  import bcs_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int PC = 4;
  typedef struct packed {
    logic w;
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } bcs_row_t;
  localparam bcs_row_t ROWS [13] = '{
    '{1'b0, 4'h9, 8'h00, 8'h09}, '{1'b0, 4'hA, 8'h00, 8'h40},
    '{1'b0, 4'hB, 8'h00, 8'h80}, '{1'b0, 4'hC, 8'h00, 8'h00},
    '{1'b0, 4'h8, 8'h00, 8'h10}, '{1'b0, 4'h0, 8'h00, 8'h00},
    '{1'b0, 4'h7, 8'h00, 8'h00}, '{1'b1, 4'h9, 8'hA5, 8'hA5},
    '{1'b1, 4'hA, 8'h9F, 8'h97}, '{1'b1, 4'hB, 8'h1F, 8'h1F},
    '{1'b1, 4'hC, 8'h10, 8'h10}, '{1'b1, 4'h0, 8'hFF, 8'h00},
    '{1'b1, 4'hD, 8'h5A, 8'h00}};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  bcs_analog_t analog_in = '0;
  logic active_done = 1'b0;
  logic ready_level = 1'b0;
  logic ready_pin;
  logic opt_reset;
  bcs_config_t cfg;
  bcs_config_t spi_cfg;
  bcs_state_t state;
  int n_errors = 0;
  int tests_run = 0;
  int n_opt = 0;
  int lo;
  logic [7:0] q;

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (opt_reset === 1'b1)
      n_opt++;
  end

  bcs_host bcs_host_inst (.sys_clk(sys_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  bcs_regs #(.SPI_VARIANT(1'b0), .PULSE_CYC(PC)) bcs_regs_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .analog_in(analog_in), .active_done(active_done),
    .ready_level(ready_level), .ready_pin(ready_pin),
    .opt_reset(opt_reset), .cfg(cfg), .state(state));

  bcs_regs #(.SPI_VARIANT(1'b1), .PULSE_CYC(PC)) bcs_regs_spi_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(),
    .analog_in(analog_in), .active_done(active_done),
    .ready_level(ready_level), .ready_pin(), .opt_reset(),
    .cfg(spi_cfg), .state());

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    cyc(1);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    cyc(1);
    chk({cfg.auto_mode, spi_cfg.auto_mode, 6'h00}, 8'h80);
    for (int i = 0; i < 13; i++)
    begin
      if (ROWS[i].w)
        bcs_host_inst.wr(ROWS[i].a, ROWS[i].d);
      bcs_host_inst.rd(ROWS[i].a, q);
      chk(q, ROWS[i].e);
    end
    $display("register table done");
    for (int c = 0; c < 5; c++)
    begin
      bcs_host_inst.wr(4'hA, {c[2:0], 2'h0, c[2:0]});
      cyc(2);
      chk({5'h00, cfg.ich}, {5'h00, c[2:0]});
      chk({5'h00, cfg.vmin}, {5'h00, c[2:0]});
    end
    chk({7'h00, cfg.capmax_hi}, 8'h01);
    bcs_host_inst.wr(4'h9, 8'h19);
    cyc(2);
    chk({cfg.vfix, cfg.vset}, 8'h19);
    bcs_host_inst.wr(4'h8, 8'h02);
    cyc(2);
    chk({7'h00, cfg.use_fixed}, 8'h01);
    bcs_host_inst.wr(4'h8, 8'h12);
    cyc(3);
    chk({7'h00, cfg.use_fixed}, 8'h00);
    chk({4'h0, state}, {4'h0, ST_CHARGE});
    $display("settings done");
    @(posedge sys_clk);
    analog_in.battery_low <= 1'b1;
    @(posedge sys_clk);
    analog_in.battery_low <= 1'b0;
    bcs_host_inst.rd(4'h0, q);
    chk(q, 8'h80);
    bcs_host_inst.wr(4'hB, 8'h90);
    @(posedge sys_clk);
    ready_level <= 1'b1;
    cyc(4);
    chk({4'h0, state}, {4'h0, ST_ACTIVE});
    chk({cfg.auto_mode, spi_cfg.auto_mode, 1'b0, cfg.ew_en, cfg.vew},
      8'h90);
    @(posedge sys_clk);
    analog_in.storage_low <= 1'b1;
    lo = 0;
    repeat (12)
    begin
      cyc(1);
      if (ready_pin === 1'b0)
        lo++;
    end
    chk(lo[7:0], PC[7:0]);
    @(posedge sys_clk);
    analog_in.storage_low <= 1'b0;
    bcs_host_inst.rd(4'h0, q);
    chk(q, 8'hC1);
    @(posedge sys_clk);
    analog_in.output_low <= 1'b1;
    cyc(3);
    chk({7'h00, ready_pin}, 8'h00);
    @(posedge sys_clk);
    analog_in.output_low <= 1'b0;
    bcs_host_inst.rd(4'h0, q);
    chk(q & 8'hE0, 8'hE0);
    @(posedge sys_clk);
    ready_level <= 1'b0;
    active_done <= 1'b1;
    @(posedge sys_clk);
    active_done <= 1'b0;
    cyc(2);
    chk({4'h0, state}, {4'h0, ST_CHARGE});
    @(posedge sys_clk);
    analog_in.charge_start <= 1'b1;
    @(posedge sys_clk);
    analog_in.charge_start <= 1'b0;
    bcs_host_inst.wr(4'h0, 8'hFF);
    bcs_host_inst.rd(4'h0, q);
    chk(q & 8'hE0, 8'h80);
    $display("status flags done");
    bcs_host_inst.wr(4'h8, 8'h16);
    cyc(3);
    chk({4'h0, state}, {4'h0, ST_ACTIVE});
    chk({5'h00, cfg.force_active, cfg.continuous,
      cfg.ondemand}, 8'h06);
    bcs_host_inst.wr(4'hB, 8'h80);
    @(posedge sys_clk);
    analog_in.storage_low <= 1'b1;
    repeat (3) @(posedge sys_clk);
    analog_in.storage_low <= 1'b0;
    bcs_host_inst.rd(4'h0, q);
    chk(q & 8'h40, 8'h00);
    lo = n_opt;
    bcs_host_inst.wr(4'h8, 8'h1A);
    bcs_host_inst.wr(4'h8, 8'h12);
    cyc(3);
    chk(8'(n_opt - lo), 8'h01);
    $display("command bits done");
    do_reset();
    bcs_host_inst.rd(4'h0, q);
    chk(q, 8'h00);
    bcs_host_inst.rd(4'h9, q);
    chk(q, 8'h09);
    bcs_host_inst.wr(4'h8, 8'h11);
    cyc(3);
    chk({4'h0, state}, {4'h0, ST_CHARGE});
    chk({6'h00, cfg.continuous, cfg.ondemand}, 8'h01);
    bcs_host_inst.wr(4'h8, 8'h10);
    cyc(2);
    chk({4'h0, state}, {4'h0, ST_STANDBY});
    $display("reset done");
    close_out();
  end
endmodule
